// file: logic/fault_telemetry_pkg.sv
/*
  Constants, register offsets and carrier types for the fault alert and
  telemetry block. Assumes a 40 MHz controller clock and decoded
  management-bus register accesses.
*/
// Notes on behaviour
// - Die temperature code above threshold register stops switching.
// - Fixed controller-die analog trip acts exactly like programmable over-temperature.
// - Power-stage trip stops switching unlatched; recovery restarts through soft-start.
// - Ready indicator high only in target, low when enable or operation off.
// - Ready indicator stays low until soft-start ramp completes.
// - Fatal alert armed once bias supply is good, regardless of enable.
// - Fatal alert goes low on over/undervoltage, over-temperature or power-stage fault.
// - Fatal alert stays latched low until supply reset or enable toggle.
// - Power-stage trip or driver undervoltage sets power-stage fault status bit.
// - Each reading except input power comes from one conversion, no averaging.
// - Currents refresh within 95 us, other readings within 190 us.
// - Input voltage reading saturates at 8 V and 16 V.
// - Input voltage code is (volts minus 8) divided by 0.03125.
// - Input current code is current times 256 over selected full scale.
// - Input power from raw voltage and current, full scale over 255.
// - Output voltage code follows 5 mV or 10 mV step setting.
// - Output current is average low-side current over each on interval.
// - Sense gain low at 15 A or more, high at 10 A or less.
// - Output current code is current times 255 over full scale.
// - Temperature code is degrees plus 40.
package fault_telemetry_pkg;
  // ********************
  // register offsets
  // ********************
  localparam logic [7:0] OFS_OPERATION   = 8'h01;
  localparam logic [7:0] OFS_OT_THRESH   = 8'h4f;
  localparam logic [7:0] OFS_OT_ACTION   = 8'h50;
  localparam logic [7:0] OFS_PIN_FS      = 8'h6b;
  localparam logic [7:0] OFS_VENDOR_STAT = 8'h80;
  localparam logic [7:0] OFS_VIN         = 8'h88;
  localparam logic [7:0] OFS_IIN         = 8'h89;
  localparam logic [7:0] OFS_VOUT        = 8'h8b;
  localparam logic [7:0] OFS_IOUT        = 8'h8c;
  localparam logic [7:0] OFS_TEMP        = 8'h8d;
  localparam logic [7:0] OFS_PIN         = 8'h97;
  localparam logic [7:0] OFS_SENSE_RES   = 8'hb3;
  localparam logic [7:0] OFS_OUTPUT_CURRENT_FULL_SCALE     = 8'hc0;
  localparam logic [7:0] OFS_PROTOCOL    = 8'hc2;
  // ********************
  // fields and reset values
  // ********************
  localparam int OPERATION_ON_BIT = 7;
  localparam int OT_RESTART_BIT   = 7;
  localparam int PS_FAULT_BIT     = 7;
  localparam logic [7:0] RST_OPERATION = 8'h80;
  localparam logic [7:0] RST_OT_THRESH = 8'ha5;
  localparam logic [7:0] RST_OT_ACTION = 8'h00;
  localparam logic [7:0] RST_PIN_FS    = 8'h00;
  localparam logic [7:0] RST_SENSE_RES = 8'h00;
  localparam logic [7:0] RST_OUTPUT_CURRENT_FULL_SCALE   = 8'h0f;
  localparam logic [7:0] RST_PROTOCOL  = 8'h01;
  localparam logic [7:0] ICC_HIGH_GAIN_MAX = 8'h0a;
  localparam logic [7:0] ICC_LOW_GAIN_MIN  = 8'h0f;
  // ********************
  // telemetry scaling
  // ********************
  localparam logic [11:0] VIN_LOW_RAW   = 12'h100;
  localparam logic [11:0] VOUT_OFS_5MV  = 12'h014;
  localparam logic [11:0] VOUT_OFS_10MV = 12'h028;
  localparam logic [8:0]  TEMP_OFFSET   = 9'h028;
  localparam int PIN_BASE_SHIFT = 21;
  // ********************
  // timing
  // ********************
  localparam int CLK_PERIOD_NS = 25;
  localparam int SLOT_TIME_NS  = 20000;
  localparam int SLOT_CYCLES   = SLOT_TIME_NS / CLK_PERIOD_NS;
  // ********************
  // types
  // ********************
  typedef enum logic [2:0] {
    MEAS_VIN, MEAS_IIN, MEAS_VOUT, MEAS_IOUT, MEAS_TEMP
  } meas_type;
  typedef struct packed {
    logic ovf_fixed;
    logic ovf_tracking;
    logic uvf_tracking;
    logic ctrl_analog_ot;
    logic ps_overtemp;
    logic driver_supply_undervoltage;
  } fault_in_type;
  typedef struct packed {
    logic       start;
    meas_type   channel;
  } adc_req_type;
endpackage : fault_telemetry_pkg

// file: logic/fault_alert_and_telemetry.sv
/*
  Fault alert, over-temperature handling, ready indicator and telemetry
  sequencer of a buck controller. Assumes analog comparators and the ADC
  are outside; the management bus is decoded into single register accesses.
*/
`timescale 1ns/1ps
`default_nettype none
module fault_alert_and_telemetry
  import fault_telemetry_pkg::*;
#(
  parameter int SLOT_LEN = SLOT_CYCLES
) (
  // clock and power-up reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // pins and analog status, asynchronous
  input  wire logic        enable_pin,
  input  wire logic        bias_supply_good,
  input  wire logic        power_input_supply_good,
  input  wire logic        soft_start_done,
  input  wire logic        output_in_target,
  input  wire fault_in_type fault_in,
  // adc, same clock
  input  wire logic        adc_valid,
  input  wire logic [11:0] adc_data,
  output var  adc_req_type adc_req,
  // decoded register access
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr_en,
  input  wire logic [7:0]  reg_wr_data,
  input  wire logic        reg_rd_en,
  output logic      [7:0]  reg_rd_data,
  // converter control
  output logic             switching_enable,
  output logic             soft_start_request,
  output logic             current_sense_high_gain,
  output logic      [7:0]  input_current_full_scale,
  // open-drain pins
  output logic             output_ready_indicator_out,
  output logic             output_ready_indicator_oe,
  output logic             fatal_fault_alert_out,
  output logic             fatal_fault_alert_oe
);
  // ********************
  // input synchronisers
  // ********************
  localparam int NSYNC = 11;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {enable_pin, bias_supply_good, power_input_supply_good,
                  soft_start_done, output_in_target, fault_in};
      sync2_q <= sync1_q;
    end
  end
  logic         en_s;
  logic         bias_s;
  logic         supply_s;
  logic         ss_done_s;
  logic         target_s;
  fault_in_type flt_s;
  assign {en_s, bias_s, supply_s, ss_done_s, target_s, flt_s} = sync2_q;

  logic en_prev_q;
  logic supply_prev_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      en_prev_q     <= 1'b0;
      supply_prev_q <= 1'b0;
    end else begin
      en_prev_q     <= en_s;
      supply_prev_q <= supply_s;
    end
  end
  // a fall of enable or of the input supply counts as the clearing event
  logic clear_evt;
  assign clear_evt = (en_prev_q & ~en_s) | (supply_prev_q & ~supply_s);

  // ********************
  // registers
  // ********************
  logic [7:0] operation_control_q;
  logic [7:0] overtemp_fault_threshold_q;
  logic [7:0] overtemp_fault_action_q;
  logic [7:0] input_power_full_scale_sel_q;
  logic [7:0] input_sense_resistor_sel_q;
  logic [7:0] output_current_full_scale_q;
  logic [7:0] voltage_step_protocol_sel_q;
  logic [7:0] vendor_fault_status_q;
  logic [7:0] input_voltage_reading_q;
  logic [7:0] input_current_reading_q;
  logic [7:0] output_voltage_reading_q;
  logic [7:0] output_current_reading_q;
  logic [7:0] die_temperature_reading_q;
  logic [7:0] input_power_reading_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      operation_control_q          <= RST_OPERATION;
      overtemp_fault_threshold_q   <= RST_OT_THRESH;
      overtemp_fault_action_q      <= RST_OT_ACTION;
      input_power_full_scale_sel_q <= RST_PIN_FS;
      input_sense_resistor_sel_q   <= RST_SENSE_RES;
      output_current_full_scale_q  <= RST_OUTPUT_CURRENT_FULL_SCALE;
      voltage_step_protocol_sel_q  <= RST_PROTOCOL;
    end else if (reg_wr_en) begin
      case (reg_addr)
        OFS_OPERATION: operation_control_q          <= reg_wr_data;
        OFS_OT_THRESH: overtemp_fault_threshold_q   <= reg_wr_data;
        OFS_OT_ACTION: overtemp_fault_action_q      <= reg_wr_data;
        OFS_PIN_FS:    input_power_full_scale_sel_q <= reg_wr_data;
        OFS_SENSE_RES: input_sense_resistor_sel_q   <= reg_wr_data;
        OFS_OUTPUT_CURRENT_FULL_SCALE:   output_current_full_scale_q  <= reg_wr_data;
        OFS_PROTOCOL:  voltage_step_protocol_sel_q  <= reg_wr_data;
        default: begin
        end
      endcase
    end
  end

  // unmapped and reserved addresses read as zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rd_data <= 8'h00;
    end else if (reg_rd_en) begin
      case (reg_addr)
        OFS_OPERATION:   reg_rd_data <= operation_control_q;
        OFS_OT_THRESH:   reg_rd_data <= overtemp_fault_threshold_q;
        OFS_OT_ACTION:   reg_rd_data <= overtemp_fault_action_q;
        OFS_PIN_FS:      reg_rd_data <= input_power_full_scale_sel_q;
        OFS_VENDOR_STAT: reg_rd_data <= vendor_fault_status_q;
        OFS_VIN:         reg_rd_data <= input_voltage_reading_q;
        OFS_IIN:         reg_rd_data <= input_current_reading_q;
        OFS_VOUT:        reg_rd_data <= output_voltage_reading_q;
        OFS_IOUT:        reg_rd_data <= output_current_reading_q;
        OFS_TEMP:        reg_rd_data <= die_temperature_reading_q;
        OFS_PIN:         reg_rd_data <= input_power_reading_q;
        OFS_SENSE_RES:   reg_rd_data <= input_sense_resistor_sel_q;
        OFS_OUTPUT_CURRENT_FULL_SCALE:     reg_rd_data <= output_current_full_scale_q;
        OFS_PROTOCOL:    reg_rd_data <= voltage_step_protocol_sel_q;
        default:         reg_rd_data <= 8'h00;
      endcase
    end
  end

  // live status, not sticky
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      vendor_fault_status_q <= 8'h00;
    end else begin
      vendor_fault_status_q <= 8'h00;
      vendor_fault_status_q[PS_FAULT_BIT] <=
        flt_s.ps_overtemp | flt_s.driver_supply_undervoltage;
    end
  end

  // ********************
  // telemetry sequencer
  // ********************
  logic [15:0] slot_cnt_q;
  logic        cur_slot_q;
  logic        cur_sel_q;
  logic [1:0]  other_idx_q;
  meas_type    pending_q;
  logic        slot_go;
  assign slot_go = (slot_cnt_q == 16'(SLOT_LEN - 1));

  // current slots alternate with the others, so iin/iout recur every 4 slots
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      slot_cnt_q  <= 16'h0000;
      cur_slot_q  <= 1'b1;
      cur_sel_q   <= 1'b0;
      other_idx_q <= 2'h0;
      adc_req     <= '{start: 1'b0, channel: MEAS_IIN};
      pending_q   <= MEAS_IIN;
    end else begin
      adc_req.start <= 1'b0;
      slot_cnt_q    <= slot_go ? 16'h0000 : slot_cnt_q + 16'h0001;
      if (slot_go) begin
        adc_req.start <= 1'b1;
        cur_slot_q    <= ~cur_slot_q;
        if (cur_slot_q) begin
          adc_req.channel <= cur_sel_q ? MEAS_IOUT : MEAS_IIN;
          pending_q       <= cur_sel_q ? MEAS_IOUT : MEAS_IIN;
          cur_sel_q       <= ~cur_sel_q;
        end else begin
          case (other_idx_q)
            2'h0:    adc_req.channel <= MEAS_VIN;
            2'h1:    adc_req.channel <= MEAS_VOUT;
            default: adc_req.channel <= MEAS_TEMP;
          endcase
          case (other_idx_q)
            2'h0:    pending_q <= MEAS_VIN;
            2'h1:    pending_q <= MEAS_VOUT;
            default: pending_q <= MEAS_TEMP;
          endcase
          other_idx_q <= (other_idx_q == 2'h2) ? 2'h0 : other_idx_q + 2'h1;
        end
      end
    end
  end

  // ********************
  // conversion to codes
  // ********************
  logic [11:0] vin_raw_q;
  logic [11:0] iin_raw_q;
  logic        pin_go_q;
  logic [11:0] vin_clip;
  logic [11:0] vout_ofs;
  logic [11:0] vout_diff;
  logic [11:0] vout_code;
  logic [19:0] iout_scaled;
  logic [12:0] temp_sum;
  logic [23:0] pin_prod;
  logic [31:0] pin_scaled;
  logic [31:0] pin_code;

  // vin raw lsb is 31.25 mV; 256 is 8 V and 511 the top code
  always_comb begin
    vin_clip = (adc_data < VIN_LOW_RAW) ? VIN_LOW_RAW : adc_data;
    vin_clip = vin_clip - VIN_LOW_RAW;
    if (vin_clip > 12'h0ff) begin
      vin_clip = 12'h0ff;
    end
  end

  // vout raw lsb is 5 mV; the 10 mV step halves the code
  always_comb begin
    vout_ofs  = (voltage_step_protocol_sel_q[1:0] == 2'b01 ||
                 voltage_step_protocol_sel_q[1:0] == 2'b10) ?
                VOUT_OFS_5MV : VOUT_OFS_10MV;
    vout_diff = (adc_data > vout_ofs) ? adc_data - vout_ofs : 12'h000;
    vout_code = (vout_ofs == VOUT_OFS_5MV) ? vout_diff : vout_diff >> 1;
    if (vout_code > 12'h0ff) begin
      vout_code = 12'h0ff;
    end
  end

  // iout raw is the low-side average as a fraction of full scale
  assign iout_scaled = ({8'h00, adc_data} << 8) - {8'h00, adc_data};
  // temperature raw is whole signed degrees
  assign temp_sum    = {adc_data[11], adc_data} + {4'h0, TEMP_OFFSET};
  // product of raw readings, full scale halved per select step
  assign pin_prod    = vin_raw_q * iin_raw_q;
  assign pin_scaled  = ({8'h00, pin_prod} << 8) - {8'h00, pin_prod};
  always_comb begin
    pin_code = pin_scaled >> (PIN_BASE_SHIFT - int'(input_power_full_scale_sel_q[1:0]));
    if (pin_code > 32'h0000_00ff) begin
      pin_code = 32'h0000_00ff;
    end
  end

  // every reading except input power is one raw result, written whole in one cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      input_voltage_reading_q   <= 8'h00;
      input_current_reading_q   <= 8'h00;
      output_voltage_reading_q  <= 8'h00;
      output_current_reading_q  <= 8'h00;
      die_temperature_reading_q <= 8'h00;
      vin_raw_q                 <= 12'h000;
      iin_raw_q                 <= 12'h000;
    end else if (adc_valid) begin
      case (pending_q)
        MEAS_VIN: begin
          input_voltage_reading_q <= vin_clip[7:0];
          vin_raw_q               <= adc_data;
        end
        MEAS_IIN: begin
          input_current_reading_q <= adc_data[11:4];
          iin_raw_q               <= adc_data;
        end
        MEAS_VOUT: output_voltage_reading_q <= vout_code[7:0];
        MEAS_IOUT: output_current_reading_q <= iout_scaled[19:12];
        MEAS_TEMP: die_temperature_reading_q <= temp_sum[12] ? 8'h00 :
                   ((|temp_sum[11:8]) ? 8'hff : temp_sum[7:0]);
        default: begin
        end
      endcase
    end
  end

  // power follows each fresh input current, one cycle later
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_go_q              <= 1'b0;
      input_power_reading_q <= 8'h00;
    end else begin
      pin_go_q <= adc_valid && (pending_q == MEAS_IIN);
      if (pin_go_q) begin
        input_power_reading_q <= pin_code[7:0];
      end
    end
  end

  // ********************
  // gain and full scale
  // ********************
  // between 10 A and 15 A the previous gain is kept
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      current_sense_high_gain  <= 1'b0;
      input_current_full_scale <= RST_SENSE_RES;
    end else begin
      if (output_current_full_scale_q >= ICC_LOW_GAIN_MIN) begin
        current_sense_high_gain <= 1'b0;
      end else if (output_current_full_scale_q <= ICC_HIGH_GAIN_MAX) begin
        current_sense_high_gain <= 1'b1;
      end
      input_current_full_scale <= input_sense_resistor_sel_q;
    end
  end

  // ********************
  // over-temperature
  // ********************
  logic ot_now;
  logic ot_latched_q;
  logic ot_prev_q;
  logic ps_prev_q;
  assign ot_now = (die_temperature_reading_q > overtemp_fault_threshold_q)
                  | flt_s.ctrl_analog_ot;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ot_latched_q <= 1'b0;
    end else if (ot_now && !overtemp_fault_action_q[OT_RESTART_BIT]) begin
      ot_latched_q <= 1'b1;
    end else if (clear_evt) begin
      ot_latched_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ot_prev_q          <= 1'b0;
      ps_prev_q          <= 1'b0;
      soft_start_request <= 1'b0;
    end else begin
      ot_prev_q <= ot_now;
      ps_prev_q <= flt_s.ps_overtemp;
      // comparator hysteresis supplies the 30 degree release point
      soft_start_request <= (ps_prev_q & ~flt_s.ps_overtemp)
                            | (ot_prev_q & ~ot_now & ~ot_latched_q);
    end
  end

  logic run_cmd;
  assign run_cmd = en_s & operation_control_q[OPERATION_ON_BIT];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      switching_enable <= 1'b0;
    end else begin
      switching_enable <= run_cmd & ~ot_now & ~ot_latched_q
                          & ~flt_s.ps_overtemp;
    end
  end

  // ********************
  // ready indicator
  // ********************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      output_ready_indicator_out <= 1'b0;
      output_ready_indicator_oe  <= 1'b1;
    end else begin
      output_ready_indicator_out <= 1'b0;
      output_ready_indicator_oe  <= ~(run_cmd & switching_enable
                                      & ss_done_s & target_s);
    end
  end

  // ********************
  // fatal fault alert
  // ********************
  logic alert_latched_q;
  logic alert_cause;
  assign alert_cause = flt_s.ovf_fixed | flt_s.ovf_tracking | flt_s.uvf_tracking
                       | ot_now | flt_s.ps_overtemp
                       | flt_s.driver_supply_undervoltage;

  // set wins over the clearing edge so no fault is lost
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      alert_latched_q <= 1'b0;
    end else if (bias_s && alert_cause) begin
      alert_latched_q <= 1'b1;
    end else if (clear_evt) begin
      alert_latched_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fatal_fault_alert_out <= 1'b0;
      fatal_fault_alert_oe  <= 1'b0;
    end else begin
      fatal_fault_alert_out <= 1'b0;
      fatal_fault_alert_oe  <= alert_latched_q;
    end
  end
endmodule : fault_alert_and_telemetry
`default_nettype wire

// file: tb/adc_model.sv
/*
  Converter model for the telemetry sequencer: answers each start.
  Assumes raw values per channel are set by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_model
  import fault_telemetry_pkg::*;
(
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // request side
  input  wire adc_req_type  adc_req,
  input  wire logic         slow,
  input  wire logic [4:0][11:0] raw,
  // result side
  output logic              adc_valid,
  output logic [11:0]       adc_data
);
  logic [3:0] wait_q;
  meas_type   ch_q;
  // data bus scrambles outside a result, nothing may read it then
  always_ff @(posedge ref_clk) begin
    adc_valid <= 1'b0;
    adc_data  <= ~adc_data;
    if (rst) begin
      wait_q <= 4'h0;
    end else if (adc_req.start) begin
      wait_q <= slow ? 4'h9 : 4'h1;
      ch_q   <= adc_req.channel;
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
      if (wait_q == 4'h1) begin
        adc_valid <= 1'b1;
        adc_data  <= raw[ch_q];
      end
    end
  end
endmodule : adc_model
`default_nettype wire

// file: tb/fault_alert_and_telemetry_chk.sv
/*
  Port checks of the fault alert and telemetry block.
  Assumes it is bound to the design top.
*/
`timescale 1ns/1ps
`default_nettype none
module telemetry_chk
  import fault_telemetry_pkg::*;
#(
  parameter int SLOT_LEN = SLOT_CYCLES
) (
  // clock and reset
  input wire logic         ref_clk,
  input wire logic         rst,
  // pins
  input wire logic         enable_pin,
  input wire logic         bias_supply_good,
  input wire logic         soft_start_done,
  input wire logic         output_in_target,
  input wire fault_in_type fault_in,
  // adc and registers
  input wire adc_req_type  adc_req,
  input wire logic [7:0]   reg_addr,
  input wire logic         reg_wr_en,
  input wire logic [7:0]   reg_wr_data,
  // outputs, and the input supply pin
  input wire logic         power_input_supply_good,
  input wire logic         switching_enable,
  input wire logic         current_sense_high_gain,
  input wire logic         output_ready_indicator_oe,
  input wire logic         fatal_fault_alert_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [15:0] gap_q;
  // ****
  // slot gap counter, too long for a repetition
  // ****
  always_ff @(posedge ref_clk) begin
    gap_q <= (rst || adc_req.start) ? 16'h0000 : gap_q + 16'h0001;
  end
  chk_slot_gap: assert property (gap_q <= 16'(SLOT_LEN))
    else $error("conversion slot overran");
  chk_start_pulse: assert property (adc_req.start |=>
    (!adc_req.start && $stable(adc_req.channel))[*8]) else $error("start not a lone pulse");
  chk_stage_stop: assert property (fault_in.ps_overtemp[*5] |-> !switching_enable)
    else $error("switching kept during stage trip");
  chk_analog_stop: assert property (fault_in.ctrl_analog_ot[*5] |-> !switching_enable)
    else $error("switching kept during analog trip");
  chk_alert_cause: assert property ((bias_supply_good &&
    (fault_in.ovf_fixed || fault_in.ps_overtemp))[*6] |-> fatal_fault_alert_oe)
    else $error("alert missing");
  chk_alert_hold: assert property ((fatal_fault_alert_oe && enable_pin &&
    power_input_supply_good)[*4] |=> fatal_fault_alert_oe) else $error("alert released");
  chk_alert_armed: assert property ((!bias_supply_good)[*6] |->
    !$rose(fatal_fault_alert_oe)) else $error("alert while unarmed");
  chk_ready_off: assert property ((!enable_pin || !output_in_target)[*5] |->
    output_ready_indicator_oe) else $error("ready while off");
  chk_ready_ramp: assert property ((!soft_start_done)[*5] |-> output_ready_indicator_oe)
    else $error("ready before ramp end");
  chk_gain_low: assert property (reg_wr_en && reg_addr == OFS_OUTPUT_CURRENT_FULL_SCALE &&
    reg_wr_data >= ICC_LOW_GAIN_MIN |-> ##3 !current_sense_high_gain) else $error("gain high");
  cover property (fatal_fault_alert_oe ##1 !fatal_fault_alert_oe);
  cover property ($fell(switching_enable));
  cover property (adc_req.start && adc_req.channel == MEAS_TEMP);
endmodule : telemetry_chk
bind fault_alert_and_telemetry telemetry_chk #(.SLOT_LEN(SLOT_LEN)) telemetry_chk_i (.*);
`default_nettype wire

// file: tb/fault_alert_and_telemetry_test.sv
/*
  Self-checking bench of the fault alert and telemetry block.
  Assumes the converter model and bound checker; slots shortened to 20.
*/
`timescale 1ns/1ps
`default_nettype none
module fault_alert_and_telemetry_test import fault_telemetry_pkg::*;;
  logic ref_clk = 1'b0, rst = 1'b1, enable_pin = 1'b1, bias_supply_good = 1'b1;
  logic power_input_supply_good = 1'b1, soft_start_done = 1'b1, output_in_target = 1'b1;
  logic reg_wr_en = 1'b0, reg_rd_en = 1'b0, slow = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00;
  fault_in_type fault_in = '0;
  logic [4:0][11:0] raw = {12'h019, 12'h800, 12'h064, 12'h5a0, 12'h140};
  logic adc_valid, switching_enable, soft_start_request, current_sense_high_gain;
  logic output_ready_indicator_out, output_ready_indicator_oe;
  logic fatal_fault_alert_out, fatal_fault_alert_oe;
  logic [11:0] adc_data;
  logic [7:0] reg_rd_data, input_current_full_scale;
  adc_req_type adc_req;
  int bad_count = 0, samples_checked = 0, ss_count = 0, ss0, i;
  logic [7:0] rw_ofs [7] = '{OFS_OPERATION, OFS_OT_THRESH, OFS_OT_ACTION, OFS_PIN_FS,
                             OFS_SENSE_RES, OFS_OUTPUT_CURRENT_FULL_SCALE, OFS_PROTOCOL};
  logic [7:0] rw_rst [7] = '{RST_OPERATION, RST_OT_THRESH, RST_OT_ACTION, RST_PIN_FS,
                             RST_SENSE_RES, RST_OUTPUT_CURRENT_FULL_SCALE, RST_PROTOCOL};
  logic [7:0] tel_ofs [6] = '{OFS_VIN, OFS_IIN, OFS_VOUT, OFS_IOUT, OFS_TEMP, OFS_PIN};
  logic [7:0] tel_exp [6] = '{8'h40, 8'h5a, 8'h50, 8'h7f, 8'h41, 8'h38};

  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (soft_start_request === 1'b1) ss_count++;

  fault_alert_and_telemetry #(.SLOT_LEN(20)) fault_alert_and_telemetry_i (.*);
  adc_model adc_model_i (.*);

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wt
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge ref_clk);
    reg_rd_en <= 1'b0;
    #1;
    check(reg_rd_data, e);
  endtask : rd
  task automatic toggle_en();
    @(posedge ref_clk);
    enable_pin <= 1'b0;
    wt(8);
    @(posedge ref_clk);
    enable_pin <= 1'b1;
    wt(8);
  endtask : toggle_en
  task automatic conclude();
    $display("compared %0d mismatched %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // ****
  // watchdog, several times the expected run
  // ****
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    conclude();
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    for (i = 0; i < 7; i++) rd(rw_ofs[i], rw_rst[i]);
    rd(8'h02, 8'h00);
    wr(OFS_VENDOR_STAT, 8'hff);
    rd(OFS_VENDOR_STAT, 8'h00);
    $display("registers done");
    wt(400);
    for (i = 0; i < 6; i++) rd(tel_ofs[i], tel_exp[i]);
    slow <= 1'b1;
    raw[0] <= 12'h400;
    raw[1] <= 12'h310;
    raw[2] <= 12'h0a0;
    wr(OFS_PROTOCOL, 8'h00);
    wt(400);
    rd(OFS_VIN, 8'hff);
    rd(OFS_IIN, 8'h31);
    rd(OFS_VOUT, 8'h3c);
    rd(OFS_PIN, 8'h61);
    raw[0] <= 12'h064;
    wr(OFS_PIN_FS, 8'h01);
    wt(400);
    rd(OFS_VIN, 8'h00);
    rd(OFS_PIN, 8'h13);
    $display("telemetry done");
    raw[4] <= 12'h03c;
    wr(OFS_OT_THRESH, 8'h63);
    wt(400);
    rd(OFS_TEMP, 8'h64);
    check(8'(switching_enable), 8'h00);
    check(8'(fatal_fault_alert_oe), 8'h01);
    check(8'({output_ready_indicator_out, fatal_fault_alert_out}), 8'h00);
    raw[4] <= 12'h019;
    wr(OFS_OT_THRESH, 8'ha5);
    wt(400);
    check(8'(switching_enable), 8'h00);
    toggle_en();
    check(8'(fatal_fault_alert_oe), 8'h00);
    check(8'(switching_enable), 8'h01);
    $display("temperature limit done");
    @(posedge ref_clk);
    fault_in <= fault_in_type'(6'h02);
    wt(8);
    check(8'(switching_enable), 8'h00);
    rd(OFS_VENDOR_STAT, 8'h80);
    ss0 = ss_count;
    fault_in <= '0;
    wt(8);
    check(8'(ss_count - ss0), 8'h01);
    check(8'(fatal_fault_alert_oe), 8'h01);
    power_input_supply_good <= 1'b0;
    wt(8);
    check(8'(fatal_fault_alert_oe), 8'h00);
    power_input_supply_good <= 1'b1;
    fault_in <= fault_in_type'(6'h01);
    wt(8);
    rd(OFS_VENDOR_STAT, 8'h80);
    fault_in <= '0;
    toggle_en();
    for (i = 2; i < 6; i++) begin
      @(posedge ref_clk);
      fault_in <= fault_in_type'(6'h01 << i);
      wt(8);
      check(8'(fatal_fault_alert_oe), 8'h01);
      fault_in <= '0;
      toggle_en();
      check(8'(fatal_fault_alert_oe), 8'h00);
    end
    bias_supply_good <= 1'b0;
    fault_in <= fault_in_type'(6'h20);
    wt(8);
    check(8'(fatal_fault_alert_oe), 8'h00);
    fault_in <= '0;
    bias_supply_good <= 1'b1;
    toggle_en();
    $display("fault alert done");
    check(8'(output_ready_indicator_oe), 8'h00);
    wr(OFS_OPERATION, 8'h00);
    wt(8);
    check(8'(output_ready_indicator_oe), 8'h01);
    wr(OFS_OPERATION, 8'h80);
    soft_start_done <= 1'b0;
    wt(8);
    check(8'(output_ready_indicator_oe), 8'h01);
    soft_start_done <= 1'b1;
    output_in_target <= 1'b0;
    wt(8);
    check(8'(output_ready_indicator_oe), 8'h01);
    output_in_target <= 1'b1;
    wt(8);
    check(8'(output_ready_indicator_oe), 8'h00);
    wr(OFS_OUTPUT_CURRENT_FULL_SCALE, 8'h0a);
    wt(3);
    check(8'(current_sense_high_gain), 8'h01);
    wr(OFS_OUTPUT_CURRENT_FULL_SCALE, 8'h0f);
    wt(3);
    check(8'(current_sense_high_gain), 8'h00);
    wr(OFS_SENSE_RES, 8'h03);
    wt(2);
    check(input_current_full_scale, 8'h03);
    $display("ready and scaling done");
    conclude();
  end
endmodule : fault_alert_and_telemetry_test
`default_nettype wire
